// *** core/dfhi_map.svh ***
// Register offsets, field positions, reset values and encodings of the filter host interface.
// Assumes a byte-addressed Wishbone slave with 32-bit data words.
`ifndef DFHI_MAP_SVH
`define DFHI_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DFHI_OFF_IN_A 8'h00
`define DFHI_OFF_IN_B 8'h04
`define DFHI_OFF_OUT_A 8'h08
`define DFHI_OFF_OUT_B 8'h0C
`define DFHI_OFF_ALIGN 8'h10
`define DFHI_OFF_KEY 8'h14
`define DFHI_OFF_STATUS 8'h18
`define DFHI_OFF_INT_EN 8'h1C
`define DFHI_OFF_SEM 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DFHI_ALIGN_OUT_BASE 2
`define DFHI_KEY_OUT_BASE 2
`define DFHI_KEY_EN_BIT 8
`define DFHI_ST_RDY_BASE 3
`define DFHI_ST_SEM_BASE 5
`define DFHI_ST_RND_BIT 2
`define DFHI_ST_SAT_BIT 1
`define DFHI_ST_RAM_BIT 0
`define DFHI_IEN_SEM_BASE 2

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define DFHI_KEY_LOW 2'h0
`define DFHI_KEY_MID 2'h1
`define DFHI_KEY_HIGH 2'h2
`define DFHI_ALIGN_RST 4'h0
`define DFHI_KEY_RST 8'hAA
`define DFHI_KEY_EN_RST 1'b1
`define DFHI_IEN_RST 5'h00

`endif

// *** core/dfhi_pkg.sv ***
// Types shared by the filter host interface and the filter core around it.
// Assumes one system clock for all parties.
package dfhi_pkg;

  // ----------------------------------------
  // Sample carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } dfhi_result_t;

  typedef struct packed {
    logic valid;
    logic chan;
    logic [23:0] data;
  } dfhi_start_t;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    DFHI_IDLE = 3'b001,
    DFHI_RUN_A = 3'b010,
    DFHI_RUN_B = 3'b100
  } dfhi_state_t;

endpackage : dfhi_pkg

// *** core/dfhi_top.sv ***
// Bus-side host interface of a two-channel filter engine, classic Wishbone slave.
// Assumes the filter core runs on clk_sys_i and pulses its result valid once per pass.
//
// How it works
// - Two 24-bit input sample registers, bus written
// - Idle waits for complete input write, then runs
// - Newest result lands in channel output register
// - Ready shown by interrupt, DMA request, status
// - Core sees MSB aligned samples and results
// - Byte shift disabled on all four after reset
// - Byte access; low three bytes of word
// - Aligned: bus 15:0 maps register 23:8
// - Align bits: in A, in B, out A, out B
// - Aligned output read in mid and low bytes
// - Input sample accepted only on key byte write
// - Output update held until key byte read
// - Coherency enable plus per-register key select
// - Key byte resets to high everywhere
// - Status: semaphores 7:5, ready B/A 4:3, 2:0
// - Write one clears interrupt-source status bit
// - Output register read clears its ready bit
// - Status bit sets only when event enabled
// - Bit 2 shows rounding active
// - Bit 1 shows clamping active
// - Bit 0 shows control store in use
// - Enable bits 0..4, ORed onto interrupt
// - Each output update raises enabled ready source
`timescale 1ns/10ps
`include "dfhi_map.svh"

module dfhi_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Filter core side
  output dfhi_pkg::dfhi_start_t start_o,
  input wire dfhi_pkg::dfhi_result_t [1:0] result_i,
  input wire logic rounding_active_i,
  input wire logic clamping_active_i,
  input wire logic ram_sel_i,
  // Notification
  output logic irq_o,
  output logic [1:0] dma_req_o
);

  // ----------------------------------------
  // Bus access
  // ----------------------------------------
  logic ack_ff, acc, wr, rd;
  logic [31:0] dat_ff;

  assign acc = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = acc && wb_we_i;
  assign rd = acc && !wb_we_i;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= acc;
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [3:0] align_ff;
  logic [7:0] key_ff;
  logic key_en_ff;
  logic [4:0] ien_ff;
  logic [2:0] sem_ff, sem_ev;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      align_ff <= `DFHI_ALIGN_RST;
      key_ff <= `DFHI_KEY_RST;
      key_en_ff <= `DFHI_KEY_EN_RST;
      ien_ff <= `DFHI_IEN_RST;
    end
    else if (wr && wb_sel_i[0])
    begin
      if (wb_adr_i == `DFHI_OFF_ALIGN)
        align_ff <= wb_dat_i[3:0];
      if (wb_adr_i == `DFHI_OFF_KEY)
        key_ff <= wb_dat_i[7:0];
      if (wb_adr_i == `DFHI_OFF_INT_EN)
        ien_ff <= wb_dat_i[4:0];
    end
    if (rst_n_i && wr && wb_sel_i[1] && wb_adr_i == `DFHI_OFF_KEY)
      key_en_ff <= wb_dat_i[`DFHI_KEY_EN_BIT];
  end

  // ----------------------------------------
  // Semaphores
  // ----------------------------------------
  assign sem_ev = (wr && wb_sel_i[0] && wb_adr_i == `DFHI_OFF_SEM) ? wb_dat_i[2:0] : 3'h0;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      sem_ff <= 3'h0;
    else if (wr && wb_sel_i[0] && wb_adr_i == `DFHI_OFF_SEM)
      sem_ff <= wb_dat_i[2:0];
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  logic [1:0] pend, take, rdy;
  logic [2:0] sem_st;
  logic [31:0] rd_in [2], rd_out [2];
  logic [23:0] in_data [2];
  logic st_wr;

  assign st_wr = wr && wb_sel_i[0] && wb_adr_i == `DFHI_OFF_STATUS;

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    localparam logic [7:0] IN_OFF = (c == 0) ? `DFHI_OFF_IN_A : `DFHI_OFF_IN_B;
    localparam logic [7:0] OUT_OFF = (c == 0) ? `DFHI_OFF_OUT_A : `DFHI_OFF_OUT_B;
    logic [23:0] in_ff, out_ff, shadow_ff, wr_val, upd_val;
    logic shadow_pend_ff, lock_ff, pend_ff, rdy_ff, dma_ff;
    logic in_al, out_al, in_hit, out_hit, key_wr, key_rd, upd;
    logic [1:0] in_key, out_key;
    logic [2:0] wr_lane, rd_lane;

    assign in_al = align_ff[c];
    assign out_al = align_ff[`DFHI_ALIGN_OUT_BASE + c];
    assign in_key = key_ff[2 * c +: 2];
    assign out_key = key_ff[2 * (`DFHI_KEY_OUT_BASE + c) +: 2];
    assign in_hit = wr && wb_adr_i == IN_OFF;
    assign out_hit = rd && wb_adr_i == OUT_OFF;

    // Byte lanes into register bytes, shifted up when aligned
    assign wr_lane = in_al ? {wb_sel_i[1:0], 1'b0} : wb_sel_i[2:0];
    assign wr_val = in_al ? {wb_dat_i[15:0], 8'h00} : wb_dat_i[23:0];
    assign rd_lane = out_al ? {wb_sel_i[1:0], 1'b0} : wb_sel_i[2:0];
    assign key_wr = (in_key == `DFHI_KEY_LOW) ? wr_lane[0] :
                    (in_key == `DFHI_KEY_MID) ? wr_lane[1] : wr_lane[2];
    assign key_rd = (out_key == `DFHI_KEY_LOW) ? rd_lane[0] :
                    (out_key == `DFHI_KEY_MID) ? rd_lane[1] : rd_lane[2];

    // Read views, upper byte reads as zero
    assign rd_in[c] = in_al ? {16'h0000, in_ff[23:8]} : {8'h00, in_ff};
    assign rd_out[c] = out_al ? {16'h0000, out_ff[23:8]} : {8'h00, out_ff};
    assign in_data[c] = in_ff;
    assign pend[c] = pend_ff;

    // Input sample register
    always_ff @(posedge clk_sys_i)
    begin
      if (!rst_n_i)
        in_ff <= 24'h00_0000;
      else if (in_hit)
      begin
        for (int k = 0; k < 3; k++)
        begin
          if (wr_lane[k])
            in_ff[8 * k +: 8] <= wr_val[8 * k +: 8];
        end
      end
    end

    // Complete sample awaiting the sequencer, new sample wins over take
    always_ff @(posedge clk_sys_i)
    begin
      if (!rst_n_i)
        pend_ff <= 1'b0;
      else if (in_hit && (key_wr || !key_en_ff) && |wr_lane)
        pend_ff <= 1'b1;
      else if (take[c])
        pend_ff <= 1'b0;
    end

    // Partial read lock
    always_ff @(posedge clk_sys_i)
    begin
      if (!rst_n_i)
        lock_ff <= 1'b0;
      else if (!key_en_ff)
        lock_ff <= 1'b0;
      else if (out_hit && |rd_lane)
        lock_ff <= !key_rd;
    end

    // Output update, deferred while locked
    assign upd = (result_i[c].valid && !lock_ff) || (shadow_pend_ff && !lock_ff);
    assign upd_val = result_i[c].valid ? result_i[c].data : shadow_ff;

    always_ff @(posedge clk_sys_i)
    begin
      if (!rst_n_i)
      begin
        out_ff <= 24'h00_0000;
        shadow_ff <= 24'h00_0000;
        shadow_pend_ff <= 1'b0;
      end
      else
      begin
        if (upd)
          out_ff <= upd_val;
        if (result_i[c].valid && lock_ff)
          shadow_ff <= result_i[c].data;
        shadow_pend_ff <= (result_i[c].valid && lock_ff) || (shadow_pend_ff && !upd);
      end
    end

    // Ready status, set wins over clear
    always_ff @(posedge clk_sys_i)
    begin
      if (!rst_n_i)
        rdy_ff <= 1'b0;
      else if (upd && ien_ff[c])
        rdy_ff <= 1'b1;
      else if (out_hit || (st_wr && wb_dat_i[`DFHI_ST_RDY_BASE + c]))
        rdy_ff <= 1'b0;
    end
    assign rdy[c] = rdy_ff;

    // Sticky DMA request until the key byte is read
    always_ff @(posedge clk_sys_i)
    begin
      if (!rst_n_i)
        dma_ff <= 1'b0;
      else if (upd)
        dma_ff <= 1'b1;
      else if (out_hit && (key_rd || !key_en_ff))
        dma_ff <= 1'b0;
    end
    assign dma_req_o[c] = dma_ff;
  end

  // ----------------------------------------
  // Semaphore status
  // ----------------------------------------
  for (genvar s = 0; s < 3; s++)
  begin : g_sem
    logic sem_st_ff;

    always_ff @(posedge clk_sys_i)
    begin
      if (!rst_n_i)
        sem_st_ff <= 1'b0;
      else if (sem_ev[s] && ien_ff[`DFHI_IEN_SEM_BASE + s])
        sem_st_ff <= 1'b1;
      else if (st_wr && wb_dat_i[`DFHI_ST_SEM_BASE + s])
        sem_st_ff <= 1'b0;
    end
    assign sem_st[s] = sem_st_ff;
  end

  assign irq_o = |{sem_st, rdy};

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  dfhi_pkg::dfhi_state_t state_ff, nxt_state;
  dfhi_pkg::dfhi_start_t start_ff;

  always_comb
  begin
    nxt_state = state_ff;
    take = 2'b00;
    case (state_ff)
      dfhi_pkg::DFHI_IDLE:
      begin
        if (pend[0])
        begin
          take = 2'b01;
          nxt_state = dfhi_pkg::DFHI_RUN_A;
        end
        else if (pend[1])
        begin
          take = 2'b10;
          nxt_state = dfhi_pkg::DFHI_RUN_B;
        end
      end
      dfhi_pkg::DFHI_RUN_A:
      begin
        if (result_i[0].valid)
          nxt_state = dfhi_pkg::DFHI_IDLE;
      end
      dfhi_pkg::DFHI_RUN_B:
      begin
        if (result_i[1].valid)
          nxt_state = dfhi_pkg::DFHI_IDLE;
      end
      default:
        nxt_state = dfhi_pkg::DFHI_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      state_ff <= dfhi_pkg::DFHI_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      start_ff <= '0;
    else
    begin
      start_ff.valid <= |take;
      if (|take)
      begin
        start_ff.chan <= take[1];
        start_ff.data <= take[1] ? in_data[1] : in_data[0];
      end
    end
  end
  assign start_o = start_ff;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `DFHI_OFF_IN_A: rd_mux = rd_in[0];
      `DFHI_OFF_IN_B: rd_mux = rd_in[1];
      `DFHI_OFF_OUT_A: rd_mux = rd_out[0];
      `DFHI_OFF_OUT_B: rd_mux = rd_out[1];
      `DFHI_OFF_ALIGN: rd_mux = {28'h000_0000, align_ff};
      `DFHI_OFF_KEY: rd_mux = {23'h00_0000, key_en_ff, key_ff};
      `DFHI_OFF_STATUS:
        rd_mux = {24'h00_0000, sem_st, rdy, rounding_active_i,
                  clamping_active_i, ram_sel_i};
      `DFHI_OFF_INT_EN: rd_mux = {27'h000_0000, ien_ff};
      `DFHI_OFF_SEM: rd_mux = {29'h0000_0000, sem_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      dat_ff <= 32'h0000_0000;
    else if (rd)
      dat_ff <= rd_mux;
  end

endmodule : dfhi_top

// *** verification/dfhi_props.sv ***
// Checker for the filter host interface ports.
// Assumes a bind to dfhi_top and the register map header.
`timescale 1ns/10ps
`include "dfhi_map.svh"

module dfhi_props (
  // Clock, reset and bus
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Core and notification
  input wire dfhi_pkg::dfhi_start_t start_o,
  input wire dfhi_pkg::dfhi_result_t [1:0] result_i,
  input wire logic rounding_active_i,
  input wire logic clamping_active_i,
  input wire logic ram_sel_i,
  input wire logic irq_o,
  input wire logic [1:0] dma_req_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic rd_tk;
  assign rd_tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;

  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("bus request not answered");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_start_pulse;
    start_o.valid |=> !start_o.valid;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse too long");
  property p_lane3;
    rd_tk && wb_adr_i < `DFHI_OFF_ALIGN |=> wb_dat_o[31:24] == 8'h00;
  endproperty
  a_lane3: assert property (p_lane3)
    else $error("unused sample lane not zero");
  property p_unmapped;
    rd_tk && wb_adr_i >= 8'h24 |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_dp_bits;
    rd_tk && wb_adr_i == `DFHI_OFF_STATUS |=>
      wb_dat_o[2:0] == $past({rounding_active_i, clamping_active_i, ram_sel_i});
  endproperty
  a_dp_bits: assert property (p_dp_bits)
    else $error("datapath status bits wrong");
  property p_irq_cause;
    $rose(irq_o) |-> $past(result_i[0].valid || result_i[1].valid || wb_cyc_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without event");
  property p_dma_clear;
    $fell(dma_req_o[0]) |-> $past(rd_tk && wb_adr_i == `DFHI_OFF_OUT_A);
  endproperty
  a_dma_clear: assert property (p_dma_clear)
    else $error("request dropped without read");
endmodule : dfhi_props

// *** verification/dfhi_core_model.sv ***
// Behavioural filter core: one pass per start, result is input plus one.
// Assumes the same clock as the host interface.
`timescale 1ns/10ps

module dfhi_core_model #(
  parameter int LAT = 4
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Core interface
  input wire dfhi_pkg::dfhi_start_t start_i,
  output dfhi_pkg::dfhi_result_t [1:0] result_o
);
  logic [3:0] cnt_ff;
  logic chan_ff;
  logic [23:0] data_ff;

  always_ff @(posedge clk_sys_i)
  begin
    result_o <= {2{1'b0, ~data_ff}};
    if (!rst_n_i)
    begin
      cnt_ff <= 4'h0;
    end
    else if (start_i.valid)
    begin
      cnt_ff <= 4'(LAT);
      chan_ff <= start_i.chan;
      data_ff <= start_i.data;
    end
    else if (cnt_ff != 4'h0)
    begin
      cnt_ff <= cnt_ff - 4'h1;
      if (cnt_ff == 4'h1)
      begin
        result_o[chan_ff] <= {1'b1, data_ff + 24'h00_0001};
      end
    end
  end
endmodule : dfhi_core_model

// *** verification/tb.sv ***
// Self-checking bench for the filter host interface over classic Wishbone.
// Assumes the core model answers each pass within a few cycles.
`timescale 1ns/10ps
`include "dfhi_map.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h exp %h", $time, (a), (e)); end end

module tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [2:0] dp_st = 3'h0;
  logic [31:0] wb_rdat;
  logic [31:0] rq;
  logic wb_ack;
  logic irq;
  logic [1:0] dma;
  dfhi_pkg::dfhi_start_t start;
  dfhi_pkg::dfhi_result_t [1:0] result;
  int miscompares = 0;
  int n_compared = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  dfhi_top dfhi_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .start_o(start),
    .result_i(result), .rounding_active_i(dp_st[2]), .clamping_active_i(dp_st[1]),
    .ram_sel_i(dp_st[0]), .irq_o(irq), .dma_req_o(dma));
  dfhi_core_model dfhi_core_model_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .start_i(start), .result_o(result));

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_wdat <= d;
    @(posedge clk_sys_i);
    while (wb_ack !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        miscompares++;
        conclude();
      end
      @(posedge clk_sys_i);
    end
    rq = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys_i);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [3:0] s, input logic [31:0] e);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    bus(1'b0, a, s, 32'h0000_0000);
    `CHK(rq & m, e)
  endtask : rd

  task automatic wait_dma(input int ch);
    int n;
    n = 0;
    while (dma[ch] !== 1'b1)
    begin
      n++;
      if (n > 40)
      begin
        miscompares++;
        conclude();
      end
      @(posedge clk_sys_i);
    end
  endtask : wait_dma

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(`DFHI_OFF_ALIGN, 4'hF, 32'h0000_0000);
    rd(`DFHI_OFF_KEY, 4'hF, 32'h0000_01AA);
    rd(`DFHI_OFF_STATUS, 4'hF, 32'h0000_0000);
    rd(8'h40, 4'hF, 32'h0000_0000);
    bus(1'b1, `DFHI_OFF_INT_EN, 4'h1, 32'h0000_0003);
    bus(1'b1, `DFHI_OFF_IN_A, 4'h7, 32'h0012_3456);
    wait_dma(0);
    `CHK(irq, 1'b1)
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_0008);
    rd(`DFHI_OFF_OUT_A, 4'h7, 32'h0012_3457);
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_0000);
    `CHK(dma[0], 1'b0)
    // --------------------------------
    // Coherency on channel B
    // --------------------------------
    bus(1'b1, `DFHI_OFF_IN_B, 4'h1, 32'h0000_0011);
    repeat (12) @(posedge clk_sys_i);
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_0000);
    bus(1'b1, `DFHI_OFF_IN_B, 4'h4, 32'h0033_0000);
    wait_dma(1);
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_0010);
    rd(`DFHI_OFF_OUT_B, 4'h1, 32'h0000_0012);
    bus(1'b1, `DFHI_OFF_IN_B, 4'h7, 32'h0044_4444);
    repeat (12) @(posedge clk_sys_i);
    bus(1'b1, `DFHI_OFF_IN_B, 4'h7, 32'h0055_5555);
    repeat (12) @(posedge clk_sys_i);
    rd(`DFHI_OFF_OUT_B, 4'h4, 32'h0033_0000);
    wait_dma(1);
    rd(`DFHI_OFF_OUT_B, 4'h7, 32'h0055_5556);
    // --------------------------------
    // Alignment and key select on A
    // --------------------------------
    bus(1'b1, `DFHI_OFF_ALIGN, 4'h1, 32'h0000_000F);
    rd(`DFHI_OFF_ALIGN, 4'h1, 32'h0000_000F);
    bus(1'b1, `DFHI_OFF_IN_A, 4'h3, 32'h0000_ABCD);
    rd(`DFHI_OFF_IN_A, 4'h3, 32'h0000_ABCD);
    wait_dma(0);
    rd(`DFHI_OFF_OUT_A, 4'h3, 32'h0000_ABCD);
    bus(1'b1, `DFHI_OFF_ALIGN, 4'h1, 32'h0000_0000);
    bus(1'b1, `DFHI_OFF_KEY, 4'h3, 32'h0000_01A8);
    bus(1'b1, `DFHI_OFF_IN_A, 4'h1, 32'h0000_0099);
    wait_dma(0);
    rd(`DFHI_OFF_OUT_A, 4'h7, 32'h00AB_CD9A);
    // --------------------------------
    // Middle key and coherency off
    // --------------------------------
    bus(1'b1, `DFHI_OFF_KEY, 4'h3, 32'h0000_0199);
    bus(1'b1, `DFHI_OFF_IN_A, 4'h1, 32'h0000_0011);
    repeat (12) @(posedge clk_sys_i);
    `CHK(dma[0], 1'b0)
    bus(1'b1, `DFHI_OFF_IN_A, 4'h2, 32'h0000_7700);
    wait_dma(0);
    rd(`DFHI_OFF_OUT_A, 4'h4, 32'h00AB_0000);
    bus(1'b1, `DFHI_OFF_IN_A, 4'h7, 32'h0012_0000);
    repeat (12) @(posedge clk_sys_i);
    rd(`DFHI_OFF_OUT_A, 4'h2, 32'h0000_7700);
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_0008);
    bus(1'b1, `DFHI_OFF_STATUS, 4'h1, 32'h0000_0008);
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_0000);
    rd(`DFHI_OFF_OUT_A, 4'h7, 32'h0012_0001);
    bus(1'b1, `DFHI_OFF_KEY, 4'h2, 32'h0000_0000);
    rd(`DFHI_OFF_KEY, 4'h3, 32'h0000_0099);
    bus(1'b1, `DFHI_OFF_IN_B, 4'h1, 32'h0000_0022);
    wait_dma(1);
    rd(`DFHI_OFF_OUT_B, 4'h1, 32'h0000_0023);
    `CHK(dma[1], 1'b0)
    // --------------------------------
    // Semaphores and status
    // --------------------------------
    bus(1'b1, `DFHI_OFF_SEM, 4'h1, 32'h0000_0007);
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_0000);
    bus(1'b1, `DFHI_OFF_INT_EN, 4'h1, 32'h0000_001C);
    rd(`DFHI_OFF_INT_EN, 4'h1, 32'h0000_001C);
    bus(1'b1, `DFHI_OFF_SEM, 4'h1, 32'h0000_0007);
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_00E0);
    rd(`DFHI_OFF_SEM, 4'h1, 32'h0000_0007);
    `CHK(irq, 1'b1)
    bus(1'b1, `DFHI_OFF_STATUS, 4'h1, 32'h0000_0020);
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_00C0);
    bus(1'b1, `DFHI_OFF_STATUS, 4'h1, 32'h0000_00C0);
    `CHK(irq, 1'b0)
    dp_st <= 3'h5;
    @(posedge clk_sys_i);
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_0005);
    dp_st <= 3'h2;
    @(posedge clk_sys_i);
    rd(`DFHI_OFF_STATUS, 4'h1, 32'h0000_0002);
    conclude();
  end
endmodule : tb

bind dfhi_top dfhi_props dfhi_props_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_o(start_o), .result_i(result_i),
  .rounding_active_i(rounding_active_i), .clamping_active_i(clamping_active_i),
  .ram_sel_i(ram_sel_i), .irq_o(irq_o), .dma_req_o(dma_req_o));
